// ---- include/i2c_ctl_pkg.sv ----
// constants for the two-wire address, divisor and slave control block
// assumes a 32-bit aligned register map reached over axi4-lite
package i2c_ctl_pkg;
    // register byte addresses
    localparam logic [31:0] OFS_TX_FIFO = 32'h4002080c;
    localparam logic [31:0] OFS_ADDR_ONE = 32'h40020818;
    localparam logic [31:0] OFS_ADDR_TWO = 32'h4002081c;
    localparam logic [31:0] OFS_START_BYTE = 32'h40020820;
    localparam logic [31:0] OFS_DIVISOR = 32'h40020824;
    localparam logic [31:0] OFS_SLAVE_CTL = 32'h40020828;
    localparam logic [31:0] OFS_IRQ_STATUS = 32'h40020840;
    localparam logic [31:0] OFS_IRQ_CLEAR = 32'h40020844;
    localparam logic [31:0] OFS_IRQ_ENABLE = 32'h40020848;
    localparam logic [31:0] OFS_MASTER_STATUS = 32'h4002084c;
    // reset values
    localparam logic [15:0] RST_DIVISOR = 16'hc6c7;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // slave control bit positions
    localparam int SC_PER_ID = 15;
    localparam int SC_TX_DMA = 14;
    localparam int SC_RX_DMA = 13;
    localparam int SC_REPST_IE = 12;
    localparam int SC_LATE_DEC = 11;
    localparam int SC_STX_IE = 10;
    localparam int SC_SRX_IE = 9;
    localparam int SC_STOP_IE = 8;
    // event bits of status, clear and enable registers
    localparam int EV_REPEAT_START_FLAG = 0;
    localparam int EV_STX = 1;
    localparam int EV_SRX = 2;
    localparam int EV_STOP = 3;
    localparam int EV_MDONE = 4;
    localparam int NUM_EV = 5;
    // address pattern and byte framing
    localparam logic [4:0] TEN_BIT_TAG = 5'h1e;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam int FIFO_DEPTH = 2;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // master sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_START = 7'h02,
        ST_BYTE = 7'h04,
        ST_RSTART = 7'h08,
        ST_RHIGH = 7'h10,
        ST_STOP = 7'h20,
        ST_SHIGH = 7'h40
    } seq_state_t;
endpackage : i2c_ctl_pkg

// ---- include/txq_if.sv ----
// bundle between the master sequencer and its two-byte transmit queue
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface txq_if;
    logic push; // write one byte
    logic [7:0] push_data; // byte to store
    logic pop; // drop the head byte
    logic [7:0] head; // oldest byte
    logic full; // no room left
    logic empty; // nothing stored
    logic [1:0] level; // bytes held
    modport user(output push, push_data, pop, input head, full, empty, level);
    modport store(input push, push_data, pop, output head, full, empty, level);
endinterface : txq_if

// ---- hdl/tx_byte_queue.sv ----
// two-entry byte queue behind the master transmit port
// ignores push while full and pop while empty
`timescale 1ns/1ps
module tx_byte_queue (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // queue bundle
    txq_if.store q
);
    logic [7:0] mem [i2c_ctl_pkg::FIFO_DEPTH]; // byte store
    logic wr_ptr; // next slot to fill
    logic rd_ptr; // slot of head

    // occupancy flags
    assign q.full = (q.level == 2'h2);
    assign q.empty = (q.level == 2'h0);
    assign q.head = mem[rd_ptr];

    // pointers and count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            q.level <= 2'h0;
        end else begin
            if (q.push && !q.full) wr_ptr <= ~wr_ptr;
            if (q.pop && !q.empty) rd_ptr <= ~rd_ptr;
            q.level <= q.level + {1'b0, q.push && !q.full} - {1'b0, q.pop && !q.empty};
        end
    end

    // storage, no reset needed
    always_ff @(posedge aclk) begin
        if (q.push && !q.full) mem[wr_ptr] <= q.push_data;
    end
endmodule : tx_byte_queue

// ---- hdl/scl_phase_timer.sv ----
// counts the length of one serial clock phase
// assumes sel_high follows the serial clock level the caller drives
`timescale 1ns/1ps
module scl_phase_timer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic sel_high,
    input wire logic [7:0] high_count,
    input wire logic [7:0] low_count,
    // end of phase
    output logic tick
);
    logic [7:0] cnt; // cycles spent in this phase

    // phase lasts count plus one cycles
    assign tick = run && (cnt == (sel_high ? high_count : low_count));

    // counter restarts at every phase end
    always_ff @(posedge aclk) begin
        if (!aresetn) cnt <= 8'h00;
        else if (!run || tick) cnt <= 8'h00;
        else cnt <= cnt + 8'h01;
    end
endmodule : scl_phase_timer

// ---- hdl/i2c_addr_clkdiv_slave_ctl.sv ----
// address bytes, start byte, clock divisor and slave control upper half
// assumes axi4-lite master, slave engine pulses synchronous to aclk
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps

module i2c_addr_clkdiv_slave_ctl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial clock line
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    // serial data line
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // from the slave engine
    input wire logic repeat_start_flag,
    input wire logic slave_tx_req,
    input wire logic slave_rx_req,
    input wire logic slave_stop_seen,
    input wire logic slave_byte_to_shadow,
    input wire logic slave_byte_sent,
    // to the slave engine and dma
    output logic per_id_txfifo_enable,
    output logic slave_tx_dma_req,
    output logic slave_rx_dma_req,
    output logic slave_tx_status_dec,
    // interrupt
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic aw_held; // write address captured
    logic w_held; // write data captured
    logic [31:0] wr_addr; // captured write address
    logic [31:0] wr_data; // captured write data
    logic [3:0] wr_strb; // captured strobes
    logic do_write; // both halves present
    logic wr_hit; // write address decodes
    logic wr_lo; // low lane enabled
    logic wr_hi; // second lane enabled
    logic [31:0] rd_data; // read mux value
    logic rd_hit; // read address decodes
    logic [7:0] addr_first_byte_field; // first address byte
    logic [7:0] addr_low_eight; // second address byte
    logic [7:0] start_byte_field; // start byte value
    logic [15:0] divisor; // high and low phase counts
    logic [7:0] slave_control; // upper half of slave control
    logic [i2c_ctl_pkg::NUM_EV-1:0] irq_status; // sticky events
    logic [i2c_ctl_pkg::NUM_EV-1:0] irq_enable; // event enables
    logic [i2c_ctl_pkg::NUM_EV-1:0] ev; // raw events
    logic [i2c_ctl_pkg::NUM_EV-1:0] ev_gate; // slave control gates
    logic [i2c_ctl_pkg::NUM_EV-1:0] clr; // clear strobes
    i2c_ctl_pkg::seq_state_t state; // master sequencer
    logic scl; // serial clock level, 1 released
    logic sda; // serial data level, 1 released
    logic [7:0] shift; // byte on the wire, msb first
    logic [3:0] bit_cnt; // bit slot, 8 is ack
    logic [1:0] step; // 0 start byte, 1 first, 2 second
    logic nack; // last ack slot saw high
    logic mdone; // sequence finished pulse
    logic go; // address write launches master
    logic tick; // phase end
    logic ten_bit; // first byte carries the ten-bit tag
    txq_if q(); // master transmit queue

    ////////////////////////////////////////////////////////////////////////
    // submodules
    tx_byte_queue u_queue (
        .aclk(aclk),
        .aresetn(aresetn),
        .q(q.store)
    );

    // phase timer halts while a slave stretches the clock low
    scl_phase_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(state != i2c_ctl_pkg::ST_IDLE && !(scl && !scl_in)),
        .sel_high(scl),
        .high_count(divisor[15:8]),
        .low_count(divisor[7:0]),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // axi write channel
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;
    assign wr_lo = wr_strb[0];
    assign wr_hi = wr_strb[1];

    // write decode, a full queue refuses its byte
    always_comb begin
        unique case (wr_addr)
            i2c_ctl_pkg::OFS_TX_FIFO: wr_hit = !q.full;
            i2c_ctl_pkg::OFS_ADDR_ONE,
            i2c_ctl_pkg::OFS_ADDR_TWO,
            i2c_ctl_pkg::OFS_START_BYTE,
            i2c_ctl_pkg::OFS_DIVISOR,
            i2c_ctl_pkg::OFS_SLAVE_CTL,
            i2c_ctl_pkg::OFS_IRQ_CLEAR,
            i2c_ctl_pkg::OFS_IRQ_ENABLE: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // capture halves in either order, answer once both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 32'h00000000;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= i2c_ctl_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? i2c_ctl_pkg::RESP_OKAY : i2c_ctl_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi read channel
    assign arready = !rvalid;

    // read mux, unused upper bits are zero
    always_comb begin
        rd_data = 32'h00000000;
        rd_hit = 1'b1;
        unique case (araddr)
            i2c_ctl_pkg::OFS_TX_FIFO: rd_data[7:0] = q.head;
            i2c_ctl_pkg::OFS_ADDR_ONE: rd_data[7:0] = addr_first_byte_field;
            i2c_ctl_pkg::OFS_ADDR_TWO: rd_data[7:0] = addr_low_eight;
            i2c_ctl_pkg::OFS_START_BYTE: rd_data[7:0] = start_byte_field;
            i2c_ctl_pkg::OFS_DIVISOR: rd_data[15:0] = divisor;
            i2c_ctl_pkg::OFS_SLAVE_CTL: rd_data[15:8] = slave_control;
            i2c_ctl_pkg::OFS_IRQ_STATUS: rd_data[4:0] = irq_status;
            i2c_ctl_pkg::OFS_IRQ_CLEAR: rd_data = 32'h00000000;
            i2c_ctl_pkg::OFS_IRQ_ENABLE: rd_data[4:0] = irq_enable;
            i2c_ctl_pkg::OFS_MASTER_STATUS:
                rd_data[3:0] = {nack, state != i2c_ctl_pkg::ST_IDLE, q.level};
            default: rd_hit = 1'b0;
        endcase
    end

    // one read at a time, data held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= i2c_ctl_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_hit ? i2c_ctl_pkg::RESP_OKAY : i2c_ctl_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_first_byte_field <= i2c_ctl_pkg::RST_BYTE;
            addr_low_eight <= i2c_ctl_pkg::RST_BYTE;
            divisor <= i2c_ctl_pkg::RST_DIVISOR;
            slave_control <= i2c_ctl_pkg::RST_BYTE;
            irq_enable <= '0;
        end else if (do_write) begin
            unique case (wr_addr)
                i2c_ctl_pkg::OFS_ADDR_ONE:
                    if (wr_lo) addr_first_byte_field <= wr_data[7:0];
                i2c_ctl_pkg::OFS_ADDR_TWO:
                    if (wr_lo) addr_low_eight <= wr_data[7:0];
                i2c_ctl_pkg::OFS_DIVISOR: begin
                    if (wr_lo) divisor[7:0] <= wr_data[7:0];
                    if (wr_hi) divisor[15:8] <= wr_data[15:8];
                end
                i2c_ctl_pkg::OFS_SLAVE_CTL:
                    if (wr_hi) slave_control <= wr_data[15:8];
                i2c_ctl_pkg::OFS_IRQ_ENABLE:
                    if (wr_lo) irq_enable <= wr_data[4:0];
                default: ;
            endcase
        end
    end

    // start byte: software value, replaced by the byte sent as start
    always_ff @(posedge aclk) begin
        if (!aresetn) start_byte_field <= i2c_ctl_pkg::RST_BYTE;
        else if (go && !q.empty) start_byte_field <= q.head;
        else if (do_write && wr_addr == i2c_ctl_pkg::OFS_START_BYTE && wr_lo)
            start_byte_field <= wr_data[7:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit queue hookup
    assign q.push = do_write && wr_addr == i2c_ctl_pkg::OFS_TX_FIFO && wr_lo;
    assign q.push_data = wr_data[7:0];
    assign q.pop = go && !q.empty;

    ////////////////////////////////////////////////////////////////////////
    // master sequencer
    assign go = do_write && wr_addr == i2c_ctl_pkg::OFS_ADDR_ONE && wr_lo
        && state == i2c_ctl_pkg::ST_IDLE;
    assign ten_bit = addr_first_byte_field[7:3] == i2c_ctl_pkg::TEN_BIT_TAG;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = scl;
    assign sda_oe_n = sda;

    // bit-level walk: start, bytes with ack slot, repeated start, stop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= i2c_ctl_pkg::ST_IDLE;
            scl <= 1'b1;
            sda <= 1'b1;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            step <= 2'h0;
            nack <= 1'b0;
            mdone <= 1'b0;
        end else begin
            mdone <= 1'b0;
            unique case (state)
                i2c_ctl_pkg::ST_IDLE: begin
                    if (go) begin
                        state <= i2c_ctl_pkg::ST_START;
                        sda <= 1'b0;
                        if (!q.empty) begin
                            shift <= q.head;
                            step <= 2'h0;
                        end else begin
                            shift <= wr_data[7:0];
                            step <= 2'h1;
                        end
                    end
                end
                i2c_ctl_pkg::ST_START: begin
                    // first low phase presents the msb
                    if (tick) begin
                        state <= i2c_ctl_pkg::ST_BYTE;
                        scl <= 1'b0;
                        sda <= shift[7];
                        bit_cnt <= 4'h0;
                    end
                end
                i2c_ctl_pkg::ST_BYTE: begin
                    if (tick && !scl) begin
                        scl <= 1'b1;
                    end else if (tick && bit_cnt == i2c_ctl_pkg::ACK_SLOT) begin
                        // end of ack slot, pick what follows
                        nack <= sda_in;
                        scl <= 1'b0;
                        bit_cnt <= 4'h0;
                        if (step == 2'h0) begin
                            state <= i2c_ctl_pkg::ST_RSTART;
                            shift <= addr_first_byte_field;
                            step <= 2'h1;
                        end else if (step == 2'h1 && ten_bit) begin
                            shift <= addr_low_eight;
                            sda <= addr_low_eight[7];
                            step <= 2'h2;
                        end else begin
                            state <= i2c_ctl_pkg::ST_STOP;
                            sda <= 1'b0;
                        end
                    end else if (tick) begin
                        // next data bit, or release for ack
                        scl <= 1'b0;
                        bit_cnt <= bit_cnt + 4'h1;
                        sda <= (bit_cnt == i2c_ctl_pkg::LAST_DATA_BIT) ? 1'b1 : shift[6];
                        shift <= {shift[6:0], 1'b0};
                    end
                end
                i2c_ctl_pkg::ST_RSTART: begin
                    // data released through a low phase
                    if (tick) begin
                        state <= i2c_ctl_pkg::ST_RHIGH;
                        scl <= 1'b1;
                    end
                end
                i2c_ctl_pkg::ST_RHIGH: begin
                    // data falls with clock high
                    if (tick) begin
                        state <= i2c_ctl_pkg::ST_START;
                        sda <= 1'b0;
                    end
                end
                i2c_ctl_pkg::ST_STOP: begin
                    if (tick) begin
                        state <= i2c_ctl_pkg::ST_SHIGH;
                        scl <= 1'b1;
                    end
                end
                i2c_ctl_pkg::ST_SHIGH: begin
                    // data rises with clock high
                    if (tick) begin
                        state <= i2c_ctl_pkg::ST_IDLE;
                        sda <= 1'b1;
                        mdone <= 1'b1;
                    end
                end
                default: begin
                    state <= i2c_ctl_pkg::ST_IDLE;
                    scl <= 1'b1;
                    sda <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // slave control outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_id_txfifo_enable <= 1'b0;
            slave_tx_dma_req <= 1'b0;
            slave_rx_dma_req <= 1'b0;
            slave_tx_status_dec <= 1'b0;
        end else begin
            per_id_txfifo_enable <= slave_control[i2c_ctl_pkg::SC_PER_ID-8];
            slave_tx_dma_req <= slave_control[i2c_ctl_pkg::SC_TX_DMA-8]
                && slave_tx_req;
            slave_rx_dma_req <= slave_control[i2c_ctl_pkg::SC_RX_DMA-8]
                && slave_rx_req;
            slave_tx_status_dec <= slave_control[i2c_ctl_pkg::SC_LATE_DEC-8]
                ? slave_byte_sent : slave_byte_to_shadow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, clear and enable
    assign ev = {mdone, slave_stop_seen, slave_rx_req, slave_tx_req, repeat_start_flag};
    assign ev_gate = {1'b1,
        slave_control[i2c_ctl_pkg::SC_STOP_IE-8],
        slave_control[i2c_ctl_pkg::SC_SRX_IE-8],
        slave_control[i2c_ctl_pkg::SC_STX_IE-8],
        slave_control[i2c_ctl_pkg::SC_REPST_IE-8]};
    assign clr = (do_write && wr_addr == i2c_ctl_pkg::OFS_IRQ_CLEAR && wr_lo)
        ? wr_data[4:0] : '0;

    // sticky bits, a new event beats its clear
    for (genvar i = 0; i < i2c_ctl_pkg::NUM_EV; i++) begin : g_ev
        always_ff @(posedge aclk) begin
            if (!aresetn) irq_status[i] <= 1'b0;
            else if (ev[i]) irq_status[i] <= 1'b1;
            else if (clr[i]) irq_status[i] <= 1'b0;
        end
    end

    // level output while any gated and enabled bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn) irq <= 1'b0;
        else irq <= |(irq_status & irq_enable & ev_gate);
    end

    // protection bits carry no meaning here
    logic unused_prot;
    assign unused_prot = ^{awprot, arprot, wr_strb[3:2], wr_data[31:16]};
endmodule : i2c_addr_clkdiv_slave_ctl

// ---- dv/bus_pullup_model.sv ----
// pulled-up serial lines with one far-side device that acknowledges
// assumes open-drain enables from the block, low meaning drive low
`timescale 1ns/1ps
module bus_pullup_model (
    // block side
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic hold_scl,
    // wire levels
    output logic scl_line,
    output logic sda_line
);
    int n = 0; // clock falls since the last start
    // a start resets the slot count
    always @(negedge sda_oe_n) if (scl_oe_n) n = 0;
    always @(negedge scl_line) n = n + 1;
    // pull-up unless driven; the device acks every ninth slot
    assign scl_line = scl_oe_n & !hold_scl;
    assign sda_line = sda_oe_n & !(n > 0 && n % 9 == 0);
endmodule : bus_pullup_model

// ---- dv/i2c_ctl_monitor.sv ----
// port assertions for the address, divisor and slave control block
// assumes it is bound onto the block and shares its one clock
`timescale 1ns/1ps
module i2c_ctl_monitor (
    // handshakes, line enable, slave engine side
    input wire logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
    input wire logic arready, rvalid, scl_oe_n, slave_tx_req, slave_rx_req,
    input wire logic slave_byte_to_shadow, slave_byte_sent, slave_tx_dma_req,
    input wire logic slave_rx_dma_req, slave_tx_status_dec
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves taken, then the answer taken
    sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
    sequence s_b_take; bvalid && bready; endsequence
    a_write_answer: assert property (s_wr_take |-> ##2 bvalid)
        else $error("write not answered");
    a_answer_once: assert property (s_b_take |=> !bvalid)
        else $error("write answered twice");
    a_ready_held: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answering");
    a_read_block: assert property (rvalid |-> !arready)
        else $error("read taken while answering");
    a_tx_dma_cause: assert property (slave_tx_dma_req |-> $past(slave_tx_req))
        else $error("tx dma without request");
    a_rx_dma_cause: assert property (slave_rx_dma_req |-> $past(slave_rx_req))
        else $error("rx dma without request");
    a_dec_cause: assert property (slave_tx_status_dec |->
        $past(slave_byte_sent || slave_byte_to_shadow)) else $error("stray decrement");
    a_low_hold: assert property ($fell(scl_oe_n) |=> !scl_oe_n)
        else $error("low phase too short");
    a_high_hold: assert property ($rose(scl_oe_n) |=> scl_oe_n)
        else $error("high phase too short");
endmodule : i2c_ctl_monitor
bind i2c_addr_clkdiv_slave_ctl i2c_ctl_monitor i2c_ctl_monitor_inst (.*);

// ---- dv/i2c_addr_clkdiv_slave_ctl_tb_top.sv ----
// self-checking bench for the address, divisor and slave control block
// assumes the pulled-up line model and the bound port monitor
`timescale 1ns/1ps
module i2c_addr_clkdiv_slave_ctl_tb_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d, bits;
    logic [5:0] ev = '0; // sent, shadow, stop, rx req, tx req, repeat start
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, scl_oe_n, sda_oe_n, scl_line, sda_line;
    logic per_id, txdma, rxdma, dec, irq, prev = 1;
    int n_mismatch = 0, n_checks = 0, cyc = 0, run = 0, lasthi, lastlo;
    logic [31:0] rows [8][3] = '{'{32'h40020824, 0, 32'hc6c7}, '{32'h4002081c, 0, 0},
        '{32'h40020820, 0, 0}, '{32'h40020828, 0, 0}, '{32'h4002081c, 32'hffffff5a, 32'h5a},
        '{32'h40020820, 32'h12a5, 32'ha5}, '{32'h40020828, 32'hffff, 32'hff00},
        '{32'h40020824, 32'h0403, 32'h0403}};
    i2c_addr_clkdiv_slave_ctl i2c_addr_clkdiv_slave_ctl_inst (.aclk, .aresetn, .awaddr,
        .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .scl_in(scl_line), .scl_out(), .scl_oe_n, .sda_in(sda_line), .sda_out(),
        .sda_oe_n, .repeat_start_flag(ev[0]), .slave_tx_req(ev[1]), .slave_rx_req(ev[2]),
        .slave_stop_seen(ev[3]), .slave_byte_to_shadow(ev[4]), .slave_byte_sent(ev[5]),
        .per_id_txfifo_enable(per_id), .slave_tx_dma_req(txdma), .slave_rx_dma_req(rxdma),
        .slave_tx_status_dec(dec), .irq);
    bus_pullup_model bus_pullup_model_inst (.scl_oe_n, .sda_oe_n, .hold_scl(1'h0), .scl_line,
        .sda_line);
    initial forever #2.5 aclk = ~aclk;
    // watchdog and serial clock phase lengths
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin n_mismatch++; close_out(); end
        if (scl_oe_n != prev) begin if (prev) lasthi = run; else lastlo = run; run = 0; end
        run++;
        prev = scl_oe_n;
    end
    always @(posedge scl_line) bits = {bits[30:0], sda_line};
    task automatic wr(input logic [31:0] a, w, output logic [1:0] o);
        @(posedge aclk) begin awaddr <= a; wdata <= w; awvalid <= 1; wvalid <= 1; bready <= 1; end
        do begin @(posedge aclk); if (awready) awvalid <= 0; if (wready) wvalid <= 0; end
        while (awvalid || wvalid);
        while (!bvalid) @(posedge aclk);
        o = bresp;
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] o);
        @(posedge aclk) begin araddr <= a; arvalid <= 1; rready <= 1; end
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        while (!rvalid) @(posedge aclk);
        o = rdata;
        r = rresp;
        rready <= 0;
    endtask : rd
    task automatic chk(input string s, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin $display("BAD %s exp %h got %h", s, e, g); n_mismatch++; end
    endtask : chk
    task automatic chkb(input string s, input logic e, g);
        chk(s, {31'h0, e}, {31'h0, g});
    endtask : chkb
    task automatic pulse(input logic [5:0] v);
        @(posedge aclk) ev <= v;
        @(posedge aclk) ev <= '0;
        #1;
    endtask : pulse
    task automatic run_master(input logic [31:0] a);
        bits = '0;
        wr(32'h40020818, a, r);
        do rd(32'h4002084c, d); while (d[2]);
    endtask : run_master
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 8; i++) begin
            if (rows[i][1] != 0) wr(rows[i][0], rows[i][1], r);
            rd(rows[i][0], d);
            chk("register", rows[i][2], d);
        end
        wr(32'h40020830, 32'h1, r);
        chk("unmapped", 32'h2, {30'h0, r});
        rd(32'h40020830, d); chk("rd unmapped", 32'h2, {30'h0, r});
        $display("register test done");
        chkb("per id", 1'h1, per_id);
        wr(32'h40020848, 32'h4, r);
        pulse(6'h20); chkb("dec late", 1'h1, dec);
        pulse(6'h10); chkb("dec early", 1'h0, dec);
        pulse(6'h02); chkb("tx dma", 1'h1, txdma);
        pulse(6'h04); chkb("rx dma", 1'h1, rxdma);
        repeat (3) @(posedge aclk);
        chkb("irq on", 1'h1, irq);
        wr(32'h40020844, 32'h4, r);
        wr(32'h40020828, 32'hf500, r);
        pulse(6'h14); chkb("dec shadow", 1'h1, dec);
        repeat (3) @(posedge aclk);
        chkb("irq gated", 1'h0, irq);
        rd(32'h40020840, d);
        chk("status", 32'h6, d);
        $display("event test done");
        run_master(32'hf2);
        chk("first byte", 32'hf2, {24'h0, bits[18:11]});
        chk("second byte", 32'h5a, {24'h0, bits[9:2]});
        chk("high phase", 32'h5, lasthi);
        chk("low phase", 32'h4, lastlo);
        wr(32'h4002080c, 32'h3c, r);
        run_master(32'h5a);
        chk("start byte", 32'h3c, {24'h0, bits[19:12]});
        rd(32'h40020820, d);
        chk("start reg", 32'h3c, d);
        $display("master test done");
        close_out();
    end
endmodule : i2c_addr_clkdiv_slave_ctl_tb_top
